/* shared/dsl_pkg.sv */
/*
 Constants for the serial word loader: word layout, sync depth, fifo
 size and link timing. Assumes a single 100 MHz system clock.
*/
// Overview of operation
// - sample data on shift clock falling edges
// - bit count survives clock pauses inside frame
// - most significant bit travels first
// - word splits into control, address, data
// - any shift clock idle level works
package dsl_pkg;
   localparam int DSL_WORD_BITS = 16;
   localparam int DSL_CTRL_LSB = 12;
   localparam int DSL_ADDR_LSB = 8;
   localparam int DSL_FIELD_BITS = 4;
   localparam int DSL_DATA_BITS = 8;
   localparam int DSL_SYNC_STAGES = 3;
   localparam int DSL_FIFO_DEPTH = 32;
   localparam int DSL_CNT_BITS = 5;
   localparam logic [4:0] DSL_LAST_BIT = 5'h0f;
   localparam logic [4:0] DSL_DONE = 5'h10;
   localparam int DSL_CLK_MHZ = 100;
   localparam int DSL_SCLK_MAX_MHZ = 40;
   // samples of the system clock per fastest shift clock period
   localparam int DSL_SAMPLES_PER_SCLK = DSL_CLK_MHZ / DSL_SCLK_MAX_MHZ;
endpackage

/* logic/dsl_loader.sv */
/*
 Serial word loader: three-wire write-only port sampled by the system
 clock, plus a word fifo toward the consumer. Assumes the shift clock
 is slow enough to be seen by edge detection on the system clock.
*/
`timescale 1ns/1ps

module dsl_fifo
   import dsl_pkg::*;
#(
   parameter int WIDTH = DSL_WORD_BITS,
   parameter int DEPTH = DSL_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("dsl_fifo: depth must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic in_ready;
      logic empty;
      logic out_valid;
      logic [WIDTH-1:0] out_data;
   } dsl_fifo_s;

   dsl_fifo_s st_reg, st_next;
   logic push, pop;

   always_comb begin
      st_next = st_reg;
      push = in_valid && st_reg.in_ready;
      pop = (st_reg.cnt != '0) && (!st_reg.out_valid || out_ready);
      if (out_ready)
         st_next.out_valid = 1'b0;
      if (pop) begin
         st_next.out_data = st_reg.mem[st_reg.rd];
         st_next.out_valid = 1'b1;
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      st_next.in_ready = st_next.cnt < (AW+1)'(DEPTH);
      st_next.empty = st_next.cnt == '0;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.in_ready <= 1'b1;
         st_reg.empty <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_ready = st_reg.in_ready;
   assign out_valid = st_reg.out_valid;
   assign out_data = st_reg.out_data;
   assign empty = st_reg.empty;

   a_fifo_full_block: assert property (@(posedge clock) disable iff (rst)
      st_reg.cnt == (AW+1)'(DEPTH) |=> st_reg.cnt <= $past(st_reg.cnt))
      else $error("fifo count grew past depth");
   a_fifo_out_hold: assert property (@(posedge clock) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("fifo output changed while stalled");
endmodule

module dsl_loader
   import dsl_pkg::*;
#(
   parameter int FIFO_DEPTH = DSL_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sclk,
   input wire logic frame_sync_n,
   input wire logic serial_data_in,
   output logic word_valid,
   input wire logic word_ready,
   output logic [DSL_FIELD_BITS-1:0] word_control,
   output logic [DSL_FIELD_BITS-1:0] word_address,
   output logic [DSL_DATA_BITS-1:0] word_data,
   output logic overrun
);
   if (DSL_SAMPLES_PER_SCLK < 2) begin
      $error("dsl_loader: system clock too slow for shift clock");
   end

   // bit order in the sync chains: {sclk, frame_sync_n, data}
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] filt;
      logic sclk_prev;
      logic [DSL_WORD_BITS-1:0] shift;
      logic [DSL_CNT_BITS-1:0] cnt;
      logic push_valid;
      logic [DSL_WORD_BITS-1:0] push_data;
      logic overrun;
   } dsl_loader_s;

   dsl_loader_s st_reg, st_next;
   logic fifo_in_ready, fifo_empty;
   logic [DSL_WORD_BITS-1:0] fifo_out;
   logic sclk_fall, in_frame;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = {sclk, frame_sync_n, serial_data_in};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < 3; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i])
            st_next.filt[i] = st_reg.s3[i];
      end
      st_next.sclk_prev = st_reg.filt[2];
      sclk_fall = st_reg.sclk_prev && !st_reg.filt[2];
      in_frame = !st_reg.filt[1];
      st_next.overrun = 1'b0;
      if (st_reg.push_valid) begin
         st_next.push_valid = !fifo_in_ready;
         st_next.overrun = !fifo_in_ready;
      end
      if (!in_frame) begin
         st_next.cnt = '0;
      end else if (sclk_fall && st_reg.cnt != DSL_DONE) begin
         // count and shift only on edges, so pauses keep state
         st_next.shift = {st_reg.shift[DSL_WORD_BITS-2:0], st_reg.filt[0]};
         st_next.cnt = st_reg.cnt + 1'b1;
         if (st_reg.cnt == DSL_LAST_BIT) begin
            st_next.push_valid = 1'b1;
            st_next.push_data = st_next.shift;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.s1 <= 3'h6;
         st_reg.s2 <= 3'h6;
         st_reg.s3 <= 3'h6;
         st_reg.filt <= 3'h6;
         st_reg.sclk_prev <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   dsl_fifo #(.WIDTH(DSL_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(st_reg.push_valid),
      .in_ready(fifo_in_ready),
      .in_data(st_reg.push_data),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(fifo_out),
      .empty(fifo_empty)
   );

   assign word_control = fifo_out[DSL_CTRL_LSB +: DSL_FIELD_BITS];
   assign word_address = fifo_out[DSL_ADDR_LSB +: DSL_FIELD_BITS];
   assign word_data = fifo_out[DSL_DATA_BITS-1:0];
   assign overrun = st_reg.overrun;

   a_bit_capture: assert property (@(posedge clock) disable iff (rst)
      sclk_fall && in_frame && st_reg.cnt < DSL_LAST_BIT
      |=> st_reg.shift[0] == $past(st_reg.filt[0]))
      else $error("bit not captured on falling edge");
   a_msb_first: assert property (@(posedge clock) disable iff (rst)
      sclk_fall && in_frame && st_reg.cnt == DSL_LAST_BIT
      |=> st_reg.push_valid
      && st_reg.push_data == {$past(st_reg.shift[14:0]), $past(st_reg.filt[0])})
      else $error("word not assembled msb first");
   a_frame_abort: assert property (@(posedge clock) disable iff (rst)
      !in_frame |=> st_reg.cnt == '0)
      else $error("bit count kept after frame end");
   a_no_early: assert property (@(posedge clock) disable iff (rst)
      $rose(st_reg.push_valid) |-> $past(st_reg.cnt) == DSL_LAST_BIT)
      else $error("word delivered before sixteenth edge");
   a_pause_hold: assert property (@(posedge clock) disable iff (rst)
      in_frame && !sclk_fall |=> st_reg.cnt == $past(st_reg.cnt))
      else $error("bit count moved without an edge");
   a_field_split: assert property (@(posedge clock) disable iff (rst)
      st_reg.push_valid && fifo_in_ready && fifo_empty && !word_valid
      |=> ##1 word_valid
      && word_control == $past(st_reg.push_data[15:12], 2)
      && word_address == $past(st_reg.push_data[11:8], 2)
      && word_data == $past(st_reg.push_data[7:0], 2))
      else $error("word fields misplaced");
   a_overrun_flag: assert property (@(posedge clock) disable iff (rst)
      st_reg.push_valid && !fifo_in_ready |=> overrun)
      else $error("lost word not flagged");
   a_one_word: assert property (@(posedge clock) disable iff (rst)
      st_reg.cnt == DSL_DONE && in_frame |=> !$rose(st_reg.push_valid))
      else $error("second word taken inside one frame");
   // a pin level only counts once two sync stages agree
   a_sync_agree: assert property (@(posedge clock) disable iff (rst)
      st_reg.s2[2] != st_reg.s3[2] |=> st_reg.filt[2] == $past(st_reg.filt[2]))
      else $error("shift clock filter moved before stages agreed");
   a_push_hold: assert property (@(posedge clock) disable iff (rst)
      st_reg.push_valid && !fifo_in_ready && !sclk_fall
      |=> st_reg.push_valid && $stable(st_reg.push_data))
      else $error("waiting word dropped or changed");
endmodule

/* testbench/dsl_host_model.sv */
/*
 Host side of the serial word loader: drives shift clock, frame sync
 and data. Assumes a 100 MHz bench clock; 80 ns shift clock period.
*/
`timescale 1ns/1ps
module dsl_host_model (
   input wire logic clock,
   output logic sclk,
   output logic frame_sync_n,
   output logic serial_data_in
);
   initial begin
      sclk <= 1'b1;
      frame_sync_n <= 1'b1;
      serial_data_in <= 1'b0;
   end
   // nbits below 16 gives a short frame; pins move on clock edges
   task automatic send(input logic [15:0] w, input int nbits,
      input bit split, input bit idle_hi);
      @(posedge clock) sclk <= idle_hi;
      repeat (4) @(posedge clock);
      frame_sync_n <= 1'b0;
      repeat (4) @(posedge clock);
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk <= 1'b1;
         serial_data_in <= w[i];
         repeat (4) @(posedge clock);
         sclk <= 1'b0;
         repeat (4) @(posedge clock);
         if (split && i == 8) begin
            sclk <= 1'b1;
            repeat (20) @(posedge clock);
         end
      end
      sclk <= idle_hi;
      repeat (4) @(posedge clock);
      frame_sync_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      repeat (10) @(posedge clock);
   endtask
endmodule

/* testbench/tb.sv */
/*
 Testbench of the serial word loader: host model in front, random
 consumer stalls behind. Assumes the loader with its word fifo.
*/
`timescale 1ns/1ps
module tb;
   import dsl_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic word_ready = 1'b0;
   logic stall = 1'b0;
   logic seen_ovr = 1'b0;
   logic sclk, frame_sync_n, serial_data_in, word_valid, overrun;
   logic [3:0] word_control, word_address;
   logic [7:0] word_data;
   logic [15:0] exp_q[$];
   logic [15:0] got_word;
   int n_fail = 0;
   int n_checks = 0;
   always #5 clock = ~clock;
   dsl_host_model host (.clock(clock), .sclk(sclk),
      .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in));
   assign got_word = {word_control, word_address, word_data};
   dsl_loader #(.FIFO_DEPTH(DSL_FIFO_DEPTH)) dut (.clock(clock),
      .rst(rst), .sclk(sclk), .frame_sync_n(frame_sync_n),
      .serial_data_in(serial_data_in), .word_valid(word_valid),
      .word_ready(word_ready), .word_control(word_control),
      .word_address(word_address), .word_data(word_data),
      .overrun(overrun));
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic put(input logic [15:0] v, input int nb, input bit sp,
      input bit ih);
      if (nb == 16)
         exp_q.push_back(v);
      host.send(v, nb, sp, ih);
   endtask
   task automatic drain(input string nm);
      for (int k = 0; k < 3000 && exp_q.size() != 0; k++)
         @(posedge clock);
      repeat (20) @(posedge clock);
      chk("queue left", 16'h0, 16'(exp_q.size()));
      $display("test %s done", nm);
   endtask
   always @(posedge clock)
      word_ready <= !stall && (($urandom % 4) != 0);
   always @(posedge clock) begin
      if (!rst && overrun === 1'b1)
         seen_ovr <= 1'b1;
      if (!rst && word_valid === 1'b1 && word_ready === 1'b1) begin
         if (exp_q.size() == 0)
            chk("extra word", 16'h0, 16'hdead);
         else
            chk("word", exp_q.pop_front(), got_word);
      end
   end
   initial begin
      void'($urandom(97486));
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      for (int i = 0; i < 16; i++)
         put(16'($urandom), 16, 1'($urandom), 1'($urandom));
      drain("random words");
      put(16'ha5c3, 10, 1'b0, 1'b1);
      put(16'h3c5a, 16, 1'b1, 1'b0);
      drain("short frame");
      @(posedge clock) stall <= 1'b1;
      // fifo memory plus output register hold depth + 1 words
      for (int i = 0; i < DSL_FIFO_DEPTH + 1; i++)
         put(16'($urandom), 16, 1'b0, 1'b1);
      repeat (20) @(posedge clock);
      chk("no overrun", 16'h0, 16'(seen_ovr));
      // this word waits at the fifo input and raises overrun
      put(16'($urandom), 16, 1'b0, 1'b1);
      repeat (20) @(posedge clock);
      chk("overrun", 16'h1, 16'(seen_ovr));
      @(posedge clock) stall <= 1'b0;
      drain("fifo full");
      tally_and_finish;
   end
   initial begin
      #300us;
      n_fail++;
      $display("BAD watchdog exp done got timeout");
      tally_and_finish;
   end
endmodule
